// ==== shared/ccpwm_defines.svh ====
// constants of the compare and pwm channel: offsets, fields, reset values, counts
`ifndef CCPWM_DEFINES_SVH
`define CCPWM_DEFINES_SVH
`define CCPWM_OFS_CTRL 5'h00
`define CCPWM_OFS_LOW 5'h04
`define CCPWM_OFS_HIGH 5'h08
`define CCPWM_OFS_PERIOD 5'h0c
`define CCPWM_OFS_TCTRL 5'h10
`define CCPWM_OFS_STATUS 5'h14
`define CCPWM_OFS_TIMER 5'h18
`define CCPWM_MODE_MSB 3
`define CCPWM_MODE_LSB 0
`define CCPWM_DC_MSB 5
`define CCPWM_DC_LSB 4
`define CCPWM_TC_PS_MSB 1
`define CCPWM_TC_PS_LSB 0
`define CCPWM_TC_ON 2
`define CCPWM_TC_POST_MSB 6
`define CCPWM_TC_POST_LSB 3
`define CCPWM_ST_FLAG 0
`define CCPWM_ST_IE 1
`define CCPWM_MODE_OFF 4'h0
`define CCPWM_MODE_TOGGLE 4'h2
`define CCPWM_MODE_SET_HI 4'h8
`define CCPWM_MODE_SET_LO 4'h9
`define CCPWM_MODE_SWINT 4'ha
`define CCPWM_MODE_SPECIAL 4'hb
`define CCPWM_PWM_MODE 2'h3
`define CCPWM_PS_DIV1 2'h0
`define CCPWM_PS_DIV4 2'h1
`define CCPWM_RST_CTRL 6'h00
`define CCPWM_RST_LOW 8'h00
`define CCPWM_RST_HIGH 8'h00
`define CCPWM_RST_PERIOD 8'hff
`define CCPWM_RST_TCTRL 7'h00
`define CCPWM_TOSC_PER_TCY 4
`define CCPWM_PRE_LIM_DIV1 6'h03
`define CCPWM_PRE_LIM_DIV4 6'h0f
`define CCPWM_PRE_LIM_DIV16 6'h3f
`endif

// ==== shared/ccpwm_pkg.sv ====
// types of the compare and pwm channel
package ccpwm_pkg;
   typedef logic [3:0] ccpwm_mode_t;
   // register and control state of one channel
   typedef struct packed {
      logic [5:0] ctrl;
      logic [7:0] low;
      logic [7:0] high;
      logic [1:0] lsb_latch;
      logic [7:0] period;
      logic [6:0] tctrl;
      logic flag;
      logic ie;
      logic pin;
      logic eq_prev;
      logic rst_first;
      logic rst_second;
      logic adc_start;
      logic ovf_block;
      logic irq;
      logic wait_q;
      logic [7:0] rdata;
   } ccpwm_chan_s;
   // state of the pwm time base
   typedef struct packed {
      logic [5:0] pre;
      logic [7:0] tmr;
      logic [3:0] post;
      logic tick;
   } ccpwm_tmr_s;
endpackage : ccpwm_pkg

// ==== verilog/ccpwm_pwm_timer.sv ====
// pwm time base: prescaler, 8-bit period timer and postscaler
`include "ccpwm_defines.svh"
module ccpwm_pwm_timer
   import ccpwm_pkg::*;
(
   input logic clk_sys,
   input logic rst_b,
   input logic timer_on,
   input logic [1:0] prescale,
   input logic [3:0] postscale,
   input logic [7:0] period,
   output logic [7:0] count,
   output logic [1:0] sub_count,
   output logic period_end,
   output logic post_tick
);
   ccpwm_tmr_s s_q;
   ccpwm_tmr_s s_d;
   logic [5:0] pre_lim;
   logic inc;

   // next state of the time base
   always_comb
   begin
      case (prescale)
         `CCPWM_PS_DIV1: pre_lim = `CCPWM_PRE_LIM_DIV1;
         `CCPWM_PS_DIV4: pre_lim = `CCPWM_PRE_LIM_DIV4;
         default: pre_lim = `CCPWM_PRE_LIM_DIV16;
      endcase
      inc = timer_on && (s_q.pre == pre_lim);
      period_end = inc && (s_q.tmr == period);
      s_d = s_q;
      s_d.tick = 1'b0;
      if (!timer_on || inc)
      begin
         s_d.pre = 6'h00;
      end
      else
      begin
         s_d.pre = s_q.pre + 6'h01;
      end
      if (period_end)
      begin
         s_d.tmr = 8'h00;
         // postscaler only paces the tick, never the period
         if (s_q.post == postscale)
         begin
            s_d.post = 4'h0;
            s_d.tick = 1'b1;
         end
         else
         begin
            s_d.post = s_q.post + 4'h1;
         end
      end
      else if (inc)
      begin
         s_d.tmr = s_q.tmr + 8'h01;
      end
      // sub-count: q phase at 1:1, top prescaler bits otherwise
      // taken from the next state so the pin falls exactly duty steps after it rose
      case (prescale)
         `CCPWM_PS_DIV1: sub_count = s_d.pre[1:0];
         `CCPWM_PS_DIV4: sub_count = s_d.pre[3:2];
         default: sub_count = s_d.pre[5:4];
      endcase
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign count = s_d.tmr; // look-ahead count, paired with the sub-count above
   assign post_tick = s_q.tick;
endmodule : ccpwm_pwm_timer

// ==== verilog/ccpwm_channel.sv ====
// compare and pwm channel with its avalon register slave
`include "ccpwm_defines.svh"
module ccpwm_channel
   import ccpwm_pkg::*;
#(
   parameter int unsigned CHANNEL_INDEX = 0
)
(
   input logic clk_sys,
   input logic rst_b,
   input logic [4:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input logic [15:0] first_compare_timer,
   input logic [15:0] second_compare_timer,
   input logic timer_select,
   input logic adc_enable,
   output logic channel_output_pin,
   output logic match_irq,
   output logic first_timer_reset,
   output logic second_timer_reset,
   output logic timer_overflow_block,
   output logic adc_start,
   output logic pwm_timer_tick
);
   // reset image of the channel
   localparam ccpwm_chan_s CHAN_RST = '{
      ctrl: `CCPWM_RST_CTRL,
      low: `CCPWM_RST_LOW,
      high: `CCPWM_RST_HIGH,
      lsb_latch: 2'h0,
      period: `CCPWM_RST_PERIOD,
      tctrl: `CCPWM_RST_TCTRL,
      wait_q: 1'b1,
      rdata: 8'h00,
      default: 1'b0
   };

   ccpwm_chan_s s_q;
   ccpwm_chan_s s_d;
   ccpwm_mode_t mode;
   logic pwm_mode;
   logic cmp_mode;
   logic [15:0] compare_value;
   logic [15:0] sel_timer;
   logic eq;
   logic ev;
   logic special;
   logic req;
   logic wr_acc;
   logic rd_take;
   logic [7:0] wbyte;
   logic [7:0] rd_mux;
   logic [9:0] duty;
   logic [7:0] pwm_count;
   logic [1:0] pwm_sub;
   logic wrap;
   logic duty_hit;
   logic tick;

   // pwm time base shared by the pwm logic below
   ccpwm_pwm_timer u_tmr (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .timer_on(s_q.tctrl[`CCPWM_TC_ON]),
      .prescale(s_q.tctrl[`CCPWM_TC_PS_MSB:`CCPWM_TC_PS_LSB]),
      .postscale(s_q.tctrl[`CCPWM_TC_POST_MSB:`CCPWM_TC_POST_LSB]),
      .period(s_q.period),
      .count(pwm_count),
      .sub_count(pwm_sub),
      .period_end(wrap),
      .post_tick(tick)
   );

   // mode decode and compare match detection
   assign mode = s_q.ctrl[`CCPWM_MODE_MSB:`CCPWM_MODE_LSB];
   assign pwm_mode = (mode[3:2] == `CCPWM_PWM_MODE);
   assign cmp_mode = (mode == `CCPWM_MODE_TOGGLE) || (mode == `CCPWM_MODE_SET_HI) ||
                     (mode == `CCPWM_MODE_SET_LO) || (mode == `CCPWM_MODE_SWINT) ||
                     (mode == `CCPWM_MODE_SPECIAL);
   assign compare_value = {s_q.high, s_q.low};
   assign sel_timer = timer_select ? second_compare_timer : first_compare_timer;
   assign eq = (compare_value == sel_timer);
   assign ev = cmp_mode && eq && !s_q.eq_prev;
   assign special = (mode == `CCPWM_MODE_SPECIAL) && (CHANNEL_INDEX < 2);

   // pwm duty value and comparison against the extended timer
   assign duty = {s_q.low, s_q.ctrl[`CCPWM_DC_MSB:`CCPWM_DC_LSB]};
   assign duty_hit = ({s_q.high, s_q.lsb_latch} == {pwm_count, pwm_sub});

   // bus handshake: request answered one cycle after it is seen
   assign req = avs_read || avs_write;
   assign rd_take = req && s_q.wait_q;
   assign wr_acc = avs_write && !s_q.wait_q && avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];

   // read data multiplexer
   always_comb
   begin
      case (avs_address)
         `CCPWM_OFS_CTRL: rd_mux = {2'b00, s_q.ctrl};
         `CCPWM_OFS_LOW: rd_mux = s_q.low;
         `CCPWM_OFS_HIGH: rd_mux = s_q.high;
         `CCPWM_OFS_PERIOD: rd_mux = s_q.period;
         `CCPWM_OFS_TCTRL: rd_mux = {1'b0, s_q.tctrl};
         `CCPWM_OFS_STATUS: rd_mux = {6'h00, s_q.ie, s_q.flag};
         `CCPWM_OFS_TIMER: rd_mux = pwm_count;
         default: rd_mux = 8'h00;
      endcase
   end

   // next state of the channel
   always_comb
   begin
      s_d = s_q;
      s_d.rst_first = 1'b0;
      s_d.rst_second = 1'b0;
      s_d.ovf_block = 1'b0;
      s_d.adc_start = 1'b0;
      s_d.eq_prev = eq;
      // handshake and read capture
      if (rd_take)
      begin
         s_d.wait_q = 1'b0;
         s_d.rdata = avs_read ? rd_mux : 8'h00;
      end
      else
      begin
         s_d.wait_q = 1'b1;
      end
      // compare match actions
      if (ev)
      begin
         case (mode)
            `CCPWM_MODE_TOGGLE: s_d.pin = !s_q.pin;
            `CCPWM_MODE_SET_HI: s_d.pin = 1'b1;
            `CCPWM_MODE_SET_LO: s_d.pin = 1'b0;
            default: s_d.pin = s_q.pin;
         endcase
         if (special)
         begin
            s_d.rst_first = !timer_select;
            s_d.rst_second = timer_select;
            s_d.ovf_block = (CHANNEL_INDEX == 1);
            s_d.adc_start = (CHANNEL_INDEX == 1) && adc_enable;
         end
      end
      // pwm output generation
      if (pwm_mode)
      begin
         if (wrap)
         begin
            s_d.pin = (duty != 10'h000);
            s_d.high = s_q.low;
            s_d.lsb_latch = s_q.ctrl[`CCPWM_DC_MSB:`CCPWM_DC_LSB];
         end
         else if (duty_hit)
         begin
            s_d.pin = 1'b0;
         end
      end
      if (mode == `CCPWM_MODE_OFF)
      begin
         s_d.pin = 1'b0;
      end
      // register writes, taken on the accepting edge
      if (wr_acc)
      begin
         case (avs_address)
            `CCPWM_OFS_CTRL:
            begin
               s_d.ctrl = wbyte[5:0];
               if (wbyte == 8'h00)
               begin
                  s_d.pin = 1'b0;
               end
               else if (wbyte[3:0] == `CCPWM_MODE_SET_HI)
               begin
                  s_d.pin = 1'b0;
               end
               else if (wbyte[3:0] == `CCPWM_MODE_SET_LO)
               begin
                  s_d.pin = 1'b1;
               end
            end
            `CCPWM_OFS_LOW: s_d.low = wbyte;
            `CCPWM_OFS_HIGH:
            begin
               if (!pwm_mode)
               begin
                  s_d.high = wbyte;
               end
            end
            `CCPWM_OFS_PERIOD: s_d.period = wbyte;
            `CCPWM_OFS_TCTRL: s_d.tctrl = wbyte[6:0];
            `CCPWM_OFS_STATUS:
            begin
               s_d.ie = wbyte[`CCPWM_ST_IE];
               if (wbyte[`CCPWM_ST_FLAG])
               begin
                  s_d.flag = 1'b0;
               end
            end
            default: s_d.flag = s_q.flag;
         endcase
      end
      // a match in the clearing cycle still sets the flag
      if (ev)
      begin
         s_d.flag = 1'b1;
      end
      s_d.irq = s_d.flag && s_d.ie;
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         s_q <= CHAN_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // pwm tick registered so every output leaves a flip-flop
   logic tick_q;
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick;
      end
   end

   // outputs
   assign avs_readdata = {24'h000000, s_q.rdata};
   assign avs_waitrequest = s_q.wait_q;
   assign channel_output_pin = s_q.pin;
   assign match_irq = s_q.irq;
   assign first_timer_reset = s_q.rst_first;
   assign second_timer_reset = s_q.rst_second;
   assign timer_overflow_block = s_q.ovf_block;
   assign adc_start = s_q.adc_start;
   assign pwm_timer_tick = tick_q;

   // checks on the channel behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   property p_set_hi;
      (ev && mode == `CCPWM_MODE_SET_HI && !wr_acc) |=> (s_q.pin && s_q.flag);
   endproperty
   a_set_hi: assert property (p_set_hi) else $error("set-high match failed");

   property p_swint;
      (ev && mode == `CCPWM_MODE_SWINT && !wr_acc) |=> (s_q.pin == $past(s_q.pin)) && s_q.flag;
   endproperty
   a_swint: assert property (p_swint) else $error("soft match touched pin");

   property p_ctrl_zero;
      (wr_acc && avs_address == `CCPWM_OFS_CTRL && wbyte == 8'h00) |=> !s_q.pin [*2];
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("pin not forced low");

   property p_wrap;
      (pwm_mode && wrap && duty != 10'h000 && !wr_acc) |=> s_q.pin && (s_q.high == $past(s_q.low));
   endproperty
   a_wrap: assert property (p_wrap) else $error("period end wrong");

   property p_duty_hit;
      (pwm_mode && !wrap && duty_hit && !wr_acc) |=> !s_q.pin;
   endproperty
   a_duty_hit: assert property (p_duty_hit) else $error("duty match kept pin");

   property p_trig_pulse;
      (s_q.rst_first || s_q.rst_second) |=> !(s_q.rst_first || s_q.rst_second);
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");

   property p_trig_sel;
      (ev && special && !timer_select) |=> (s_q.rst_first && !s_q.rst_second);
   endproperty
   a_trig_sel: assert property (p_trig_sel) else $error("wrong timer reset");

   property p_ovf;
      s_q.ovf_block |-> (s_q.rst_first || s_q.rst_second);
   endproperty
   a_ovf: assert property (p_ovf) else $error("stray overflow block");

   property p_adc;
      s_q.adc_start |-> $past(adc_enable) && (CHANNEL_INDEX == 1);
   endproperty
   a_adc: assert property (p_adc) else $error("conversion start unexpected");

   property p_high_ro;
      (pwm_mode && !wrap && wr_acc && avs_address == `CCPWM_OFS_HIGH) |=>
         (s_q.high == $past(s_q.high));
   endproperty
   a_high_ro: assert property (p_high_ro) else $error("active high written");

   property p_flag_sticky;
      (s_q.flag && !wr_acc) |=> s_q.flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

   c_match: cover property (ev ##1 s_q.flag);
   c_wrap: cover property (pwm_mode && wrap);
   c_trig: cover property (s_q.rst_first || s_q.rst_second);
   c_write: cover property (wr_acc);
endmodule : ccpwm_channel

// ==== testbench/ccpwm_pin_monitor.sv ====
// far side model: measures high time and period on the channel output pin
module ccpwm_pin_monitor
(
   input wire logic clk_sys,
   input wire logic channel_output_pin,
   output int high_len,
   output int period_len
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   logic last = 1'b0;
   // clocks since the last rising edge, latched at each rise and fall
   always @(posedge clk_sys)
   begin
      cnt = cnt + 1;
      if (channel_output_pin === 1'b1 && last !== 1'b1)
      begin
         period_len = cnt;
         cnt = 0;
      end
      if (channel_output_pin === 1'b0 && last === 1'b1)
         high_len = cnt;
      last = channel_output_pin;
   end
endmodule : ccpwm_pin_monitor

// ==== testbench/ccpwm_channel_tb.sv ====
// self-checking bench of the compare and pwm channel
`include "ccpwm_defines.svh"
module ccpwm_channel_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] first_compare_timer = 16'h0;
   logic [15:0] second_compare_timer = 16'h0;
   logic timer_select = 1'b0;
   logic adc_enable = 1'b0;
   logic channel_output_pin, match_irq, first_timer_reset, second_timer_reset;
   logic timer_overflow_block, adc_start, pwm_timer_tick;
   logic [31:0] rd;
   int num_errors = 0;
   int n_compared = 0;
   int high_len, period_len;
   int n_rst1 = 0, n_rst2 = 0, n_blk = 0, n_adc = 0;
   int tick_gap = 0, tick_len = 0;

   // clock of 50 ns
   always #25 clk_sys = ~clk_sys;

   // tally of the one-cycle trigger pulses
   always @(posedge clk_sys)
   begin
      n_rst1 += int'(first_timer_reset === 1'b1);
      n_rst2 += int'(second_timer_reset === 1'b1);
      n_blk += int'(timer_overflow_block === 1'b1);
      n_adc += int'(adc_start === 1'b1);
      // clocks between two pwm timer ticks
      tick_gap += 1;
      if (pwm_timer_tick === 1'b1)
      begin
         tick_len = tick_gap;
         tick_gap = 0;
      end
   end

   ccpwm_channel #(.CHANNEL_INDEX(1)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .first_compare_timer(first_compare_timer), .second_compare_timer(second_compare_timer),
      .timer_select(timer_select), .adc_enable(adc_enable),
      .channel_output_pin(channel_output_pin), .match_irq(match_irq),
      .first_timer_reset(first_timer_reset), .second_timer_reset(second_timer_reset),
      .timer_overflow_block(timer_overflow_block), .adc_start(adc_start),
      .pwm_timer_tick(pwm_timer_tick));

   ccpwm_pin_monitor i_mon (.clk_sys(clk_sys), .channel_output_pin(channel_output_pin),
      .high_len(high_len), .period_len(period_len));

   // compare and report one value
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // verdict and end of run
   task end_sim;
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   // one avalon access, held until waitrequest is seen low
   task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // let the accepting edge settle before callers look at outputs
      @(negedge clk_sys);
   endtask : bus

   task wreg(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wreg

   task rreg(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask : rreg

   // move the selected timer onto v, the other stays at zero
   task hit(input logic [15:0] v, input logic sel);
      @(posedge clk_sys);
      timer_select <= sel;
      first_compare_timer <= sel ? 16'h0 : v - 16'h1;
      second_compare_timer <= sel ? v - 16'h1 : 16'h0;
      repeat (2) @(posedge clk_sys);
      first_compare_timer <= sel ? 16'h0 : v;
      second_compare_timer <= sel ? v : 16'h0;
      repeat (4) @(posedge clk_sys);
   endtask : hit

   // pin must hold v for 300 clocks
   task steady(input logic v);
      int bad;
      bad = 0;
      repeat (300)
      begin
         @(posedge clk_sys);
         bad += int'(channel_output_pin !== v);
      end
      chk(bad, 0);
   endtask : steady

   // reset values, unused control bits, unmapped place
   task t_reset;
      rreg(`CCPWM_OFS_CTRL, 32'h0);
      rreg(`CCPWM_OFS_PERIOD, 32'hff);
      rreg(`CCPWM_OFS_STATUS, 32'h0);
      rreg(5'h1c, 32'h0);
      wreg(`CCPWM_OFS_CTRL, 8'hff);
      rreg(`CCPWM_OFS_CTRL, 32'h3f);
      wreg(`CCPWM_OFS_CTRL, 8'h00);
   endtask : t_reset

   // drive high, drive low and toggle on match, on both timers
   task t_compare;
      wreg(`CCPWM_OFS_LOW, 8'h34);
      wreg(`CCPWM_OFS_HIGH, 8'h12);
      wreg(`CCPWM_OFS_CTRL, {4'h0, `CCPWM_MODE_SET_HI});
      chk(channel_output_pin, 1'b0);
      hit(16'h1234, 1'b0);
      chk(channel_output_pin, 1'b1);
      rreg(`CCPWM_OFS_STATUS, 32'h1);
      wreg(`CCPWM_OFS_STATUS, 8'h01);
      rreg(`CCPWM_OFS_STATUS, 32'h0);
      wreg(`CCPWM_OFS_CTRL, {4'h0, `CCPWM_MODE_SET_LO});
      chk(channel_output_pin, 1'b1);
      hit(16'h1234, 1'b1);
      chk(channel_output_pin, 1'b0);
      wreg(`CCPWM_OFS_CTRL, {4'h0, `CCPWM_MODE_TOGGLE});
      hit(16'h1234, 1'b0);
      chk(channel_output_pin, 1'b1);
      hit(16'h1234, 1'b1);
      chk(channel_output_pin, 1'b0);
      hit(16'h1234, 1'b0);
      wreg(`CCPWM_OFS_CTRL, 8'h00);
      chk(channel_output_pin, 1'b0);
      wreg(`CCPWM_OFS_STATUS, 8'h01);
   endtask : t_compare

   // software interrupt only, gated by its enable
   task t_swint;
      wreg(`CCPWM_OFS_CTRL, {4'h0, `CCPWM_MODE_SWINT});
      wreg(`CCPWM_OFS_STATUS, 8'h02);
      hit(16'h1234, 1'b0);
      chk(channel_output_pin, 1'b0);
      chk(match_irq, 1'b1);
      wreg(`CCPWM_OFS_STATUS, 8'h03);
      @(posedge clk_sys);
      chk(match_irq, 1'b0);
      wreg(`CCPWM_OFS_STATUS, 8'h00);
      hit(16'h1234, 1'b1);
      chk(match_irq, 1'b0);
      rreg(`CCPWM_OFS_STATUS, 32'h1);
      wreg(`CCPWM_OFS_STATUS, 8'h01);
   endtask : t_swint

   // special event on each timer, conversion start only when enabled
   task t_special;
      int b1, b2, bb, ba;
      wreg(`CCPWM_OFS_CTRL, {4'h0, `CCPWM_MODE_SPECIAL});
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk_sys);
         adc_enable <= s[0];
         b1 = n_rst1;
         b2 = n_rst2;
         bb = n_blk;
         ba = n_adc;
         hit(16'h1234, s[0]);
         chk(n_rst1 - b1, 1 - s);
         chk(n_rst2 - b2, s);
         chk(n_blk - bb, 1);
         chk(n_adc - ba, s);
         chk(channel_output_pin, 1'b0);
      end
      wreg(`CCPWM_OFS_CTRL, 8'h00);
   endtask : t_special

   // pwm period and high time for each prescale, then duty edge cases
   task t_pwm;
      int fac;
      for (int ps = 0; ps < 3; ps++)
      begin
         fac = 1 << (2 * ps);
         wreg(`CCPWM_OFS_CTRL, 8'h00);
         wreg(`CCPWM_OFS_PERIOD, 8'h03);
         wreg(`CCPWM_OFS_LOW, 8'h01);
         wreg(`CCPWM_OFS_CTRL, 8'h20);
         wreg(`CCPWM_OFS_TCTRL, 8'h1c | 8'(ps));
         wreg(`CCPWM_OFS_CTRL, 8'h2c);
         repeat (128 * fac + 20) @(posedge clk_sys);
         chk(period_len, 16 * fac);
         chk(high_len, 6 * fac);
         chk(tick_len, 64 * fac);
         rreg(`CCPWM_OFS_HIGH, 32'h01);
      end
      wreg(`CCPWM_OFS_HIGH, 8'h55);
      rreg(`CCPWM_OFS_HIGH, 32'h01);
      wreg(`CCPWM_OFS_LOW, 8'h10);
      repeat (600) @(posedge clk_sys);
      steady(1'b1);
      wreg(`CCPWM_OFS_CTRL, 8'h00);
      chk(channel_output_pin, 1'b0);
      wreg(`CCPWM_OFS_LOW, 8'h00);
      wreg(`CCPWM_OFS_CTRL, 8'h0c);
      repeat (600) @(posedge clk_sys);
      steady(1'b0);
   endtask : t_pwm

   // main sequence
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_compare();
      t_swint();
      t_special();
      t_pwm();
      end_sim();
   end

   // watchdog against a hung handshake
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      end_sim();
   end
endmodule : ccpwm_channel_tb
